// ===== hw/ccd_map.vh
`ifndef CCD_MAP_VH
`define CCD_MAP_VH

// sizes
`define CCD_NUM_CTR       5
`define CCD_CMD_W         8
`define CCD_CNT_W         16

// command fields
`define CCD_OP_MSB        7
`define CCD_OP_LSB        5
`define CCD_SEL_MSB       4
`define CCD_SEL_LSB       0
`define CCD_IDX_MSB       2
`define CCD_IDX_LSB       0
`define CCD_STEP_PFX_MSB  7
`define CCD_STEP_PFX_LSB  3

// mask command opcodes
`define CCD_OP_ARM        3'h1
`define CCD_OP_LOAD       3'h2
`define CCD_OP_LDARM      3'h3
`define CCD_OP_DISSAVE    3'h4
`define CCD_OP_SAVE       3'h5
`define CCD_OP_DISARM     3'h6

// single counter step command
`define CCD_STEP_PFX      5'h1e
`define CCD_IDX_FIRST     3'h1
`define CCD_IDX_LAST      3'h5

// reset and count values
`define CCD_CMD_RST       8'h00
`define CCD_CNT_RST       16'h0000
`define CCD_CNT_ONE       16'h0001
`define CCD_CNT_MAX       16'hffff
`define CCD_MASK_RST      5'h00
`define CCD_SELHOLD_RST   5'h1f
`endif

// ===== hw/ccd_cmd_decode.v
`include "ccd_map.vh"

module ccd_cmd_decode (
   // command byte
   input  wire [7:0] i_cmd,
   input  wire       i_valid,
   // per counter action masks
   output reg  [4:0] o_arm_mask,
   output reg  [4:0] o_load_mask,
   output reg  [4:0] o_disarm_mask,
   output reg  [4:0] o_save_mask,
   output reg  [4:0] o_step_mask,
   output reg        o_ldarm
);
   wire [2:0] op;
   wire [4:0] sel;
   wire [2:0] idx;
   wire       is_step;

   assign op  = i_cmd[`CCD_OP_MSB:`CCD_OP_LSB];
   assign sel = i_cmd[`CCD_SEL_MSB:`CCD_SEL_LSB];
   assign idx = i_cmd[`CCD_IDX_MSB:`CCD_IDX_LSB];
   assign is_step = (i_cmd[`CCD_STEP_PFX_MSB:`CCD_STEP_PFX_LSB]
                     == `CCD_STEP_PFX);

   always @* begin
      o_arm_mask    = `CCD_MASK_RST;
      o_load_mask   = `CCD_MASK_RST;
      o_disarm_mask = `CCD_MASK_RST;
      o_save_mask   = `CCD_MASK_RST;
      o_step_mask   = `CCD_MASK_RST;
      o_ldarm       = 1'b0;
      if (i_valid) begin
         case (op)
            `CCD_OP_ARM:     o_arm_mask = sel;
            `CCD_OP_LOAD:    o_load_mask = sel;
            `CCD_OP_LDARM: begin
               o_load_mask = sel;
               o_arm_mask  = sel;
               o_ldarm     = 1'b1;
            end
            `CCD_OP_DISSAVE: begin
               o_disarm_mask = sel;
               o_save_mask   = sel;
            end
            `CCD_OP_SAVE:    o_save_mask = sel;
            `CCD_OP_DISARM:  o_disarm_mask = sel;
            default: begin
               // other codes in this group stay ignored
               if (is_step && idx >= `CCD_IDX_FIRST &&
                   idx <= `CCD_IDX_LAST)
                  o_step_mask = 5'h01 << (idx - `CCD_IDX_FIRST);
            end
         endcase
      end
   end
endmodule

// ===== hw/ccd_counter_command.v
`include "ccd_map.vh"

module ccd_counter_command (
   // clock, reset, enable
   input  wire        i_clk,
   input  wire        i_sys_rst,
   input  wire        i_ce,
   // control port
   input  wire        i_cmd_wr,
   input  wire [7:0]  i_cmd_data,
   // per counter configuration
   input  wire [4:0]  i_count_direction_bit,
   input  wire [4:0]  i_reload_source_bit,
   input  wire [4:0]  i_gate_reload_mode,
   input  wire [4:0]  i_once_mode,
   // per counter live inputs
   input  wire [4:0]  i_src_edge,
   input  wire [4:0]  i_gate,
   input  wire [79:0] i_load_val,
   // command register view
   output wire [7:0]  o_command_entry,
   output wire        o_cmd_pending,
   // per counter state
   output wire [79:0] o_count_val,
   output wire [79:0] o_hold_val,
   output wire [4:0]  o_armed,
   output wire [4:0]  o_terminal_count,
   output wire [4:0]  o_disarm_pending,
   output wire [4:0]  o_reload_sel_hold
);
   // command register and its execute flag
   reg  [7:0]  command_entry_reg;
   reg         exec_reg;

   // counter state
   reg  [15:0] cnt_reg [0:4];
   reg  [15:0] hold_reg [0:4];
   reg  [4:0]  armed_reg;
   reg  [4:0]  tc_reg;
   reg  [4:0]  pend_reg;
   reg  [4:0]  sel_hold_reg;

   reg  [15:0] cnt_next [0:4];
   reg  [15:0] hold_next [0:4];
   reg  [4:0]  armed_next;
   reg  [4:0]  tc_next;
   reg  [4:0]  pend_next;
   reg  [4:0]  sel_hold_next;

   // decoded action masks
   wire [4:0]  arm_mask;
   wire [4:0]  load_mask;
   wire [4:0]  disarm_mask;
   wire [4:0]  save_mask;
   wire [4:0]  step_mask;
   wire        ldarm;

   // per counter scratch
   reg  [15:0] ld_v;
   reg  [15:0] hd_v;
   reg         alt;
   reg         cnt_ev;
   reg         cmd_hit;
   reg  [15:0] tc_src;
   reg  [15:0] ld_src;
   integer     i;
   // own index for the clocked loops so no variable has two drivers
   integer     j;

   // one count in the configured direction
   function [15:0] f_step;
      input [15:0] val;
      input        up;
      begin
         if (up)
            f_step = val + `CCD_CNT_ONE;
         else
            f_step = val - `CCD_CNT_ONE;
      end
   endfunction

   // counter is one count short of terminal count
   function f_at_pre;
      input [15:0] val;
      input        up;
      begin
         if (up)
            f_at_pre = (val == `CCD_CNT_MAX);
         else
            f_at_pre = (val == `CCD_CNT_ONE);
      end
   endfunction

   function [15:0] f_pick;
      input [15:0] ld;
      input [15:0] hd;
      input        use_hold;
      begin
         if (use_hold)
            f_pick = hd;
         else
            f_pick = ld;
      end
   endfunction

   ccd_cmd_decode u_decode (
      .i_cmd         (command_entry_reg),
      .i_valid       (exec_reg),
      .o_arm_mask    (arm_mask),
      .o_load_mask   (load_mask),
      .o_disarm_mask (disarm_mask),
      .o_save_mask   (save_mask),
      .o_step_mask   (step_mask),
      .o_ldarm       (ldarm)
   );

   // command capture: decoded and applied the cycle after the write
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         command_entry_reg <= `CCD_CMD_RST;
         exec_reg          <= 1'b0;
      end else if (i_ce) begin
         exec_reg <= i_cmd_wr;
         if (i_cmd_wr)
            command_entry_reg <= i_cmd_data;
      end
   end

   // next state for every counter; one pass so all selected
   // counters change on the same edge
   always @* begin
      ld_v    = `CCD_CNT_RST;
      hd_v    = `CCD_CNT_RST;
      alt     = 1'b0;
      cnt_ev  = 1'b0;
      cmd_hit = 1'b0;
      tc_src  = `CCD_CNT_RST;
      ld_src  = `CCD_CNT_RST;
      armed_next    = armed_reg;
      tc_next       = tc_reg;
      pend_next     = pend_reg;
      sel_hold_next = sel_hold_reg;
      for (i = 0; i < `CCD_NUM_CTR; i = i + 1) begin
         cnt_next[i]  = cnt_reg[i];
         hold_next[i] = hold_reg[i];
         ld_v = i_load_val[i*16 +: 16];
         hd_v = hold_reg[i];
         alt  = i_reload_source_bit[i] & ~i_gate_reload_mode[i];
         cmd_hit = arm_mask[i] | load_mask[i] | disarm_mask[i] |
                   save_mask[i] | step_mask[i];
         // reload value a terminal count would use
         if (i_gate_reload_mode[i])
            tc_src = f_pick(ld_v, hd_v, i_gate[i]);
         else if (!i_reload_source_bit[i])
            tc_src = ld_v;
         else
            tc_src = f_pick(ld_v, hd_v, sel_hold_reg[i]);
         // value a plain load copies in
         if (i_gate_reload_mode[i])
            ld_src = tc_src;
         else if (i_reload_source_bit[i] && armed_reg[i])
            ld_src = tc_src;
         else
            ld_src = ld_v;
         // a coincident source edge yields to a command on this
         // counter; async load-and-arm is a host hazard anyway
         cnt_ev = (i_src_edge[i] & armed_reg[i] & ~cmd_hit) |
                  step_mask[i];
         if (cnt_ev) begin
            if (tc_reg[i]) begin
               tc_next[i]  = 1'b0;
               cnt_next[i] = f_step(cnt_reg[i],
                                    i_count_direction_bit[i]);
               if (pend_reg[i]) begin
                  armed_next[i] = 1'b0;
                  pend_next[i]  = 1'b0;
               end
            end else if (f_at_pre(cnt_reg[i],
                                  i_count_direction_bit[i])) begin
               cnt_next[i] = tc_src;
               tc_next[i]  = 1'b1;
               if (alt)
                  sel_hold_next[i] = ~sel_hold_reg[i];
               if (i_once_mode[i])
                  armed_next[i] = 1'b0;
            end else begin
               cnt_next[i] = f_step(cnt_reg[i],
                                    i_count_direction_bit[i]);
            end
         end
         if (load_mask[i]) begin
            if (tc_reg[i]) begin
               // ends terminal count, selector left alone
               tc_next[i]  = 1'b0;
               cnt_next[i] = ld_src;
               if (pend_reg[i]) begin
                  armed_next[i] = 1'b0;
                  pend_next[i]  = 1'b0;
               end
            end else if (f_at_pre(cnt_reg[i],
                                  i_count_direction_bit[i])) begin
               cnt_next[i] = tc_src;
               tc_next[i]  = 1'b1;
               if (alt)
                  sel_hold_next[i] = ~sel_hold_reg[i];
               if (i_once_mode[i])
                  armed_next[i] = 1'b0;
            end else begin
               cnt_next[i] = ld_src;
            end
         end
         // arm part comes after the load part
         if (arm_mask[i]) begin
            armed_next[i] = 1'b1;
            if (alt)
               sel_hold_next[i] = 1'b1;
            if (ldarm)
               pend_next[i] = 1'b0;
         end
         if (disarm_mask[i]) begin
            if (tc_reg[i])
               pend_next[i] = 1'b1;
            else
               armed_next[i] = 1'b0;
         end
         if (save_mask[i])
            hold_next[i] = cnt_reg[i];
      end
   end

   // state registers; clock enable freezes everything
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         armed_reg    <= `CCD_MASK_RST;
         tc_reg       <= `CCD_MASK_RST;
         pend_reg     <= `CCD_MASK_RST;
         sel_hold_reg <= `CCD_SELHOLD_RST;
         for (j = 0; j < `CCD_NUM_CTR; j = j + 1) begin
            cnt_reg[j]  <= `CCD_CNT_RST;
            hold_reg[j] <= `CCD_CNT_RST;
         end
      end else if (i_ce) begin
         armed_reg    <= armed_next;
         tc_reg       <= tc_next;
         pend_reg     <= pend_next;
         sel_hold_reg <= sel_hold_next;
         for (j = 0; j < `CCD_NUM_CTR; j = j + 1) begin
            cnt_reg[j]  <= cnt_next[j];
            hold_reg[j] <= hold_next[j];
         end
      end
   end

   // flatten arrays onto ports
   genvar g;
   generate
      for (g = 0; g < `CCD_NUM_CTR; g = g + 1) begin : g_out
         assign o_count_val[g*16 +: 16] = cnt_reg[g];
         assign o_hold_val[g*16 +: 16]  = hold_reg[g];
      end
   endgenerate

   assign o_command_entry   = command_entry_reg;
   assign o_cmd_pending     = exec_reg;
   assign o_armed           = armed_reg;
   assign o_terminal_count  = tc_reg;
   assign o_disarm_pending  = pend_reg;
   assign o_reload_sel_hold = sel_hold_reg;
endmodule

// ===== tb/ccd_counter_command_asserts.sv
module ccd_counter_command_asserts (
   // clock and reset
   input wire        i_clk,
   input wire        i_sys_rst,
   // control port and configuration
   input wire        i_ce,
   input wire        i_cmd_wr,
   input wire [7:0]  i_cmd_data,
   input wire [4:0]  i_reload_source_bit,
   input wire [4:0]  i_gate_reload_mode,
   input wire [79:0] i_load_val,
   // counter state
   input wire [7:0]  o_command_entry,
   input wire [79:0] o_count_val,
   input wire [79:0] o_hold_val,
   input wire [4:0]  o_armed,
   input wire [4:0]  o_terminal_count,
   input wire [4:0]  o_disarm_pending
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       w;
   logic [4:0] m1;
   logic [4:0] m2;
   assign w = i_ce & i_cmd_wr;
   // select mask delayed to the edges at which a command lands
   always @(posedge i_clk) begin
      m1 <= i_cmd_data[4:0];
      m2 <= m1;
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   AST_CAPTURE: assert property (
      w |=> o_command_entry == $past(i_cmd_data))
      else $error("command byte not captured");
   AST_ARM: assert property (
      w && i_cmd_data[7:5] == 3'h1 ##1 i_ce |=> (o_armed & m2) == m2)
      else $error("selected counters not armed");
   AST_DISARM: assert property (
      w && i_cmd_data[7:5] == 3'h6 ##1 i_ce
      && (o_terminal_count & m1) == 5'h00 |=> (o_armed & m2) == 5'h00)
      else $error("selected counters still armed");
   AST_DEFER: assert property (
      w && i_cmd_data[7:5] == 3'h6 ##1 i_ce
      && (o_terminal_count & o_armed & m1) == m1
      |=> (o_disarm_pending & o_armed & m2) == m2)
      else $error("disarm in terminal count not deferred");
   AST_SAVE: assert property (
      w && i_cmd_data == 8'ha1 ##1 i_ce
      |=> o_hold_val[15:0] == $past(o_count_val[15:0]))
      else $error("save did not copy the count");
   AST_DIS_SAVE: assert property (
      w && i_cmd_data == 8'h81 ##1 i_ce && !o_terminal_count[0]
      |=> !o_armed[0] && o_hold_val[15:0] == $past(o_count_val[15:0]))
      else $error("disarm and save wrong");
   AST_LOAD: assert property (
      w && i_cmd_data == 8'h41 ##1 i_ce && !i_reload_source_bit[0]
      && !i_gate_reload_mode[0]
      |=> o_count_val[15:0] == $past(i_load_val[15:0]))
      else $error("load did not copy the load value");
   AST_UNUSED: assert property (
      w && i_cmd_data[7:4] == 4'he ##1 i_ce |=> $stable(o_hold_val))
      else $error("foreign code changed state");
endmodule

// ===== tb/ccd_host.sv
module ccd_host (
   // clock
   input  wire        i_clk,
   // control port
   output logic       o_cmd_wr,
   output logic [7:0] o_cmd_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_cmd_wr = 1'b0;
      o_cmd_data = 8'h00;
   end
   // data idles inverted so a stale byte never passes for a fresh one
   task automatic put(input logic [7:0] cmd);
      @(posedge i_clk);
      #1;
      o_cmd_wr = 1'b1;
      o_cmd_data = cmd;
      @(posedge i_clk);
      #1;
      o_cmd_wr = 1'b0;
      o_cmd_data = ~cmd;
   endtask
endmodule

// ===== tb/tb.sv
bind ccd_counter_command ccd_counter_command_asserts ccd_asserts_inst (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_cmd_wr(i_cmd_wr),
   .i_cmd_data(i_cmd_data), .i_reload_source_bit(i_reload_source_bit),
   .i_gate_reload_mode(i_gate_reload_mode),
   .i_load_val(i_load_val), .o_command_entry(o_command_entry),
   .o_count_val(o_count_val), .o_hold_val(o_hold_val), .o_armed(o_armed),
   .o_terminal_count(o_terminal_count), .o_disarm_pending(o_disarm_pending));

module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic [4:0]  dir = 5'h02;
   logic [4:0]  src = 5'h00;
   logic [4:0]  rsrc = 5'h00;
   logic [4:0]  gmode = 5'h00;
   logic [4:0]  once = 5'h00;
   logic [4:0]  gate = 5'h00;
   logic        ce = 1'b1;
   logic        cpend;
   logic [79:0] ld = {16'h0015, 16'h0014, 16'h0013, 16'h0012, 16'h0011};
   logic        cmd_wr;
   logic [7:0]  cmd_data;
   logic [7:0]  cmd_entry;
   logic [79:0] cnt;
   logic [79:0] hold;
   logic [4:0]  armed;
   logic [4:0]  tc;
   logic [4:0]  dpend;
   logic [4:0]  selh;
   int          num_errors = 0;
   int          cmp_count = 0;
   // defined codes that belong to other blocks; undefined ones stay unsent
   logic [7:0]  bad [5] = '{8'h01, 8'he9, 8'he1, 8'he8, 8'hee};
   always #5 i_clk = ~i_clk;
   ccd_host ccd_host_inst (.i_clk(i_clk), .o_cmd_wr(cmd_wr),
      .o_cmd_data(cmd_data));
   ccd_counter_command ccd_counter_command_inst (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_ce(ce), .i_cmd_wr(cmd_wr),
      .i_cmd_data(cmd_data), .i_count_direction_bit(dir),
      .i_reload_source_bit(rsrc), .i_gate_reload_mode(gmode),
      .i_once_mode(once), .i_src_edge(src), .i_gate(gate),
      .i_load_val(ld), .o_command_entry(cmd_entry), .o_cmd_pending(cpend),
      .o_count_val(cnt), .o_hold_val(hold), .o_armed(armed),
      .o_terminal_count(tc), .o_disarm_pending(dpend),
      .o_reload_sel_hold(selh));
   task automatic chk_f(input logic [4:0] g, input logic [4:0] e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask
   // state lands one edge after the write edge
   task automatic wr(input logic [7:0] c);
      ccd_host_inst.put(c);
      chk_f({4'h0, cpend}, 5'h01);
      @(posedge i_clk);
      #1;
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge i_clk);
      #1 src = m;
      @(posedge i_clk);
      #1 src = 5'h00;
   endtask
   task automatic conclude;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      conclude;
   end
   initial begin
      repeat (5) @(posedge i_clk);
      #1 i_sys_rst = 1'b0;
      chk_f(armed, 5'h00);
      chk_f(selh, 5'h1f);
      chk_v(cnt[15:0], 16'h0000);
      wr(8'h5f);
      for (int k = 0; k < 5; k++)
         chk_v(cnt[16*k +: 16], 16'h0011 + 16'(k));
      chk_f(armed, 5'h00);
      chk_v({8'h00, cmd_entry}, 16'h005f);
      wr(8'h25);
      chk_f(armed, 5'h05);
      wr(8'h22);
      chk_f(armed, 5'h07);
      foreach (bad[i])
         wr(bad[i]);
      chk_f(armed, 5'h07);
      chk_v(cnt[63:48], 16'h0014);
      pulse(5'h09);
      chk_v(cnt[15:0], 16'h0010);
      chk_v(cnt[63:48], 16'h0014);
      wr(8'hf4);
      chk_v(cnt[63:48], 16'h0013);
      wr(8'hf2);
      chk_v(cnt[31:16], 16'h0013);
      wr(8'ha1);
      chk_v(hold[15:0], 16'h0010);
      chk_f(armed, 5'h07);
      wr(8'hc4);
      chk_f(armed, 5'h03);
      wr(8'hf1);
      wr(8'h81);
      chk_f(armed, 5'h02);
      chk_v(hold[15:0], 16'h000f);
      wr(8'h41);
      chk_v(cnt[15:0], 16'h0011);
      chk_v(hold[15:0], 16'h000f);
      dir = 5'h00;
      ld[31:16] = 16'h0002;
      wr(8'h42);
      chk_v(cnt[31:16], 16'h0002);
      pulse(5'h02);
      pulse(5'h02);
      chk_f(tc, 5'h02);
      wr(8'hc2);
      chk_f(dpend, 5'h02);
      chk_f(armed, 5'h02);
      wr(8'h62);
      chk_f(tc, 5'h00);
      chk_f(dpend, 5'h00);
      chk_f(armed, 5'h02);
      pulse(5'h02);
      wr(8'h42);
      chk_f(tc, 5'h02);
      chk_v(cnt[31:16], 16'h0002);
      wr(8'h42);
      chk_f(tc, 5'h00);
      // counter five: alternating reload, gate reload, one-shot, freeze
      wr(8'hb0);
      chk_v(hold[79:64], 16'h0015);
      ld[79:64] = 16'h0002;
      wr(8'h50);
      chk_v(cnt[79:64], 16'h0002);
      rsrc = 5'h10;
      wr(8'h30);
      chk_f(armed, 5'h12);
      pulse(5'h10);
      pulse(5'h10);
      chk_v(cnt[79:64], 16'h0015);
      chk_f(selh, 5'h0f);
      pulse(5'h10);
      wr(8'h50);
      chk_v(cnt[79:64], 16'h0002);
      chk_f(selh, 5'h0f);
      pulse(5'h10);
      wr(8'h50);
      chk_f(tc, 5'h10);
      chk_f(selh, 5'h1f);
      pulse(5'h10);
      wr(8'h70);
      chk_f(tc, 5'h10);
      chk_v(cnt[79:64], 16'h0015);
      chk_f(selh, 5'h1f);
      wr(8'h50);
      chk_f(tc, 5'h00);
      chk_v(cnt[79:64], 16'h0015);
      rsrc = 5'h00;
      gmode = 5'h10;
      wr(8'h50);
      chk_v(cnt[79:64], 16'h0002);
      gate = 5'h10;
      wr(8'h50);
      chk_v(cnt[79:64], 16'h0015);
      gmode = 5'h00;
      gate = 5'h00;
      once = 5'h10;
      ld[79:64] = 16'h0001;
      wr(8'h50);
      pulse(5'h10);
      chk_f(armed, 5'h02);
      wr(8'h70);
      chk_f(armed, 5'h12);
      chk_f(tc, 5'h00);
      // with the enable low neither the write nor the edge may land
      ce = 1'b0;
      ccd_host_inst.put(8'hdf);
      pulse(5'h10);
      ce = 1'b1;
      chk_f(armed, 5'h12);
      chk_v(cnt[79:64], 16'h0001);
      conclude;
   end
endmodule
